// ==== wdt_pkg.sv ====
package wdt_pkg;
  localparam int unsigned APB_AW = 32;
  localparam int unsigned APB_DW = 32;
  localparam logic [31:0] MODE_CONFIG_ADDR = 32'hfffff6d0;
  localparam logic [31:0] KICK_ADDR = 32'hfffff6d4;
  localparam logic [31:0] KICK_BIT_ADDR = 32'hfffff6d8;
  localparam logic [7:0] MODE_CONFIG_RESET = 8'h67;
  localparam logic [7:0] KICK_CODE = 8'hac;
  localparam logic [7:0] KICK_READ_IDLE = 8'h1a;
  localparam logic [7:0] KICK_READ_RUN = 8'h9a;
  localparam logic [7:0] MODE_RSVD_MASK = 8'h98;
  localparam int unsigned MODE_HI_POS = 6;
  localparam int unsigned MODE_LO_POS = 5;
  localparam int unsigned INTERVAL_MSB = 2;
  localparam int unsigned INTERVAL_LSB = 0;
  localparam int unsigned INTERVAL_W = 3;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned PRESCALE_LOG2 = 9;
  localparam int unsigned INTERVAL_BASE_LOG2 = 9;
  localparam int unsigned NMI_WIDTH_LOG2 = 7;
  localparam int unsigned NMI_WIDTH_CYCLES = 1 << NMI_WIDTH_LOG2;
  localparam logic [3:0] BYTE0_STRB = 4'h1;

  typedef enum logic [1:0] {
    act_none,
    act_nmi,
    act_reset
  } action_t;
endpackage

// ==== wdt_count_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface wdt_count_if;
  import wdt_pkg::*;
  logic run;
  logic clear;
  logic hold;
  logic [INTERVAL_W-1:0] interval;
  logic overflow;

  modport ctrl (
    output run,
    output clear,
    output hold,
    output interval,
    input overflow
  );
  modport counter (
    input run,
    input clear,
    input hold,
    input interval,
    output overflow
  );
endinterface
`default_nettype wire

// ==== wdt_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
  parameter int unsigned PRESCALE_W = wdt_pkg::PRESCALE_LOG2,
  parameter int unsigned CNT_W = wdt_pkg::COUNT_W
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  wdt_count_if.counter cnt
);
  import wdt_pkg::*;

  logic [PRESCALE_W-1:0] prescale;
  logic [CNT_W-1:0] count;
  logic tick;
  logic [CNT_W-1:0] limit;

  // one enable pulse every 2^9 peripheral clocks
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prescale <= '0;
    end else if (!cnt.run || cnt.clear || cnt.hold) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  assign tick = cnt.run && !cnt.clear && !cnt.hold && (&prescale);

  // interval n spans 2^(9+n) ticks of the watchdog clock
  always_comb begin
    limit = '0;
    for (int i = 0; i < CNT_W; i++) begin
      if (i < int'(cnt.interval) + int'(INTERVAL_BASE_LOG2)) begin
        limit[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
    end else if (cnt.clear || cnt.hold) begin
      count <= '0;
    end else if (tick) begin
      if (count == limit) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  assign cnt.overflow = tick && (count == limit);
endmodule
`default_nettype wire

// ==== wdt_top.sv ====
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [wdt_pkg::APB_AW-1:0] paddr_i,
  input wire logic [wdt_pkg::APB_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [wdt_pkg::APB_DW-1:0] prdata_o,
  output logic pslverr_o,
  output logic overflow_nmi_request_o,
  output logic overflow_internal_reset_o
);
  import wdt_pkg::*;

  wdt_count_if cnt_if ();

  logic [7:0] watchdog_mode_config;
  logic [1:0] mode_writes;
  logic running;
  logic nmi_active;
  logic [NMI_WIDTH_LOG2-1:0] nmi_count;
  logic reset_latched;

  logic access;
  logic wr;
  logic hit_mode;
  logic hit_kick;
  logic hit_bit;
  logic mapped;
  logic byte_ok;
  logic mode_wr;
  logic kick_wr;
  logic kick_good;
  logic kick_bad;
  logic mode_second;
  logic bit_access;
  logic fire;
  logic next_running;
  action_t action;

  function automatic action_t decode_action(input logic [7:0] cfg);
    if (cfg[MODE_HI_POS]) begin
      decode_action = act_reset;
    end else if (cfg[MODE_LO_POS]) begin
      decode_action = act_nmi;
    end else begin
      decode_action = act_none;
    end
  endfunction

  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign hit_mode = (paddr_i == MODE_CONFIG_ADDR);
  assign hit_kick = (paddr_i == KICK_ADDR);
  assign hit_bit = (paddr_i == KICK_BIT_ADDR);
  assign mapped = hit_mode || hit_kick || hit_bit;
  assign byte_ok = (pstrb_i == BYTE0_STRB);

  // zero wait states: every access completes in its first access cycle
  assign pready_o = psel_i && penable_i;

  always_comb begin
    pslverr_o = 1'b0;
    if (access) begin
      if (!mapped) begin
        pslverr_o = 1'b1;
      end else if (pwrite_i && !hit_bit && !byte_ok) begin
        pslverr_o = 1'b1;
      end
    end
  end

  assign mode_wr = wr && hit_mode && byte_ok;
  assign kick_wr = wr && hit_kick && byte_ok;
  assign kick_good = kick_wr && (pwdata_i[7:0] == KICK_CODE);
  assign kick_bad = kick_wr && (pwdata_i[7:0] != KICK_CODE) && running;
  assign mode_second = mode_wr && (mode_writes == 2'd1) && running;
  assign bit_access = access && hit_bit;

  assign action = decode_action(watchdog_mode_config);

  // the bus cannot express single-bit accesses, so they use an alias word
  assign fire = (cnt_if.overflow && running) || kick_bad || mode_second;

  // write-once mode register; a write count saturates at two
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      watchdog_mode_config <= MODE_CONFIG_RESET;
    end else if (mode_wr && (mode_writes == 2'd0)) begin
      watchdog_mode_config <= pwdata_i[7:0] & ~MODE_RSVD_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_writes <= 2'd0;
    end else if (mode_wr && (mode_writes != 2'd2)) begin
      mode_writes <= mode_writes + 2'd1;
    end
  end

  always_comb begin
    next_running = running;
    if (kick_good) begin
      next_running = 1'b1;
    end
  end

  // no path ever clears running apart from reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      running <= 1'b0;
    end else begin
      running <= next_running;
    end
  end

  // counter runs only once started with a non-stop mode
  assign cnt_if.run = running && (action != act_none);
  assign cnt_if.clear = kick_good;
  assign cnt_if.hold = nmi_active;
  assign cnt_if.interval = watchdog_mode_config[INTERVAL_MSB:INTERVAL_LSB];

  // nmi stretches 2^7 clocks while the counter waits, then counting resumes
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_active <= 1'b0;
    end else if (fire && (action == act_nmi) && !nmi_active) begin
      nmi_active <= 1'b1;
    end else if (nmi_active && (&nmi_count)) begin
      nmi_active <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_count <= '0;
    end else if (nmi_active) begin
      nmi_count <= nmi_count + 1'b1;
    end else begin
      nmi_count <= '0;
    end
  end

  // internal reset is held until the system reset pulls rstn_i low
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_latched <= 1'b0;
    end else if (bit_access) begin
      reset_latched <= 1'b1;
    end else if (fire && (action == act_reset)) begin
      reset_latched <= 1'b1;
    end
  end

  assign overflow_nmi_request_o = nmi_active;
  assign overflow_internal_reset_o = reset_latched;

  // read data is loaded in the setup cycle, stands through the access cycle and is zero again after it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (paddr_i == MODE_CONFIG_ADDR) begin
        prdata_o <= {24'h000000, watchdog_mode_config};
      end else if (paddr_i == KICK_ADDR) begin
        prdata_o <= {24'h000000, (running ? KICK_READ_RUN : KICK_READ_IDLE)};
      end else begin
        prdata_o <= '0;
      end
    end else begin
      prdata_o <= '0;
    end
  end

  wdt_counter #(
    .PRESCALE_W(PRESCALE_LOG2),
    .CNT_W(COUNT_W)
  ) u_counter (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .cnt(cnt_if.counter)
  );
endmodule
`default_nettype wire

// ==== wdt_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_top_assertions (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [wdt_pkg::APB_AW-1:0] paddr_i,
  input wire logic [wdt_pkg::APB_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic [wdt_pkg::APB_DW-1:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic overflow_nmi_request_o,
  input wire logic overflow_internal_reset_o
);
  import wdt_pkg::*;
  logic ap;
  logic kicked;
  logic [8:0] ncnt;
  assign ap = psel_i && penable_i;
  // cycles the nmi request has stood high so far
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) ncnt <= 9'h000;
    else ncnt <= overflow_nmi_request_o ? ncnt + 9'h001 : 9'h000;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) kicked <= 1'b0;
    else if (ap && pwrite_i && paddr_i == KICK_ADDR && pstrb_i == BYTE0_STRB && pwdata_i[7:0] == KICK_CODE) kicked <= 1'b1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_ready; pready_o == ap; endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  property p_idle; !ap |-> prdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_rsvd; ap && !pwrite_i && paddr_i == MODE_CONFIG_ADDR |-> (prdata_o & 32'hffffff98) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("mode reserved bits set");
  property p_kread; ap && !pwrite_i && paddr_i == KICK_ADDR && !kicked |-> prdata_o == {24'h0, KICK_READ_IDLE}; endproperty
  a_kread: assert property (p_kread) else $error("kick read before start");
  property p_quiet; !kicked |-> !overflow_nmi_request_o; endproperty
  a_quiet: assert property (p_quiet) else $error("nmi before start");
  property p_nlen; $fell(overflow_nmi_request_o) |-> ncnt == 9'h080; endproperty
  a_nlen: assert property (p_nlen) else $error("nmi width");
  property p_nmax; ncnt <= 9'h080; endproperty
  a_nmax: assert property (p_nmax) else $error("nmi too long");
  property p_sticky; overflow_internal_reset_o |=> overflow_internal_reset_o; endproperty
  a_sticky: assert property (p_sticky) else $error("reset dropped");
  property p_alias; ap && paddr_i == KICK_BIT_ADDR |-> ##[1:2] overflow_internal_reset_o; endproperty
  a_alias: assert property (p_alias) else $error("bit access no reset");
  property p_strb; ap && pwrite_i && pstrb_i != BYTE0_STRB && paddr_i != KICK_BIT_ADDR |-> pslverr_o; endproperty
  a_strb: assert property (p_strb) else $error("wide write accepted");
  c_nmi: cover property ($rose(overflow_nmi_request_o));
  c_rst: cover property ($rose(overflow_internal_reset_o));
  c_run: cover property (ap && !pwrite_i && prdata_o == {24'h0, KICK_READ_RUN});
endmodule
bind wdt_top wdt_top_assertions chk (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .overflow_nmi_request_o, .overflow_internal_reset_o);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  import wdt_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic pready_o, pslverr_o, overflow_nmi_request_o, overflow_internal_reset_o;
  logic [31:0] prdata_o, rdata;
  logic [7:0] rm [2] = '{8'h40, 8'h60};
  int n_fail = 0;
  int n_checks = 0;
  int n;
  wdt_top dut (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .pready_o, .prdata_o, .pslverr_o, .overflow_nmi_request_o, .overflow_internal_reset_o);
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s, input logic ee);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    pstrb_i <= s;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    rdata = prdata_o;
    `CHK(pslverr_o, ee)
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, BYTE0_STRB, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] ed);
    xfer(1'b0, a, 8'h00, 4'h0, 1'b0);
    `CHK(rdata, {24'h0, ed})
  endtask
  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    end_sim();
  end
  initial begin
    do_reset();
    rd(MODE_CONFIG_ADDR, MODE_CONFIG_RESET);
    rd(KICK_ADDR, KICK_READ_IDLE);
    xfer(1'b1, 32'hfffff6dc, 8'h11, BYTE0_STRB, 1'b1);
    xfer(1'b1, MODE_CONFIG_ADDR, 8'h00, 4'h3, 1'b1);
    wr(KICK_ADDR, 8'h55);
    rd(KICK_ADDR, KICK_READ_IDLE);
    wr(MODE_CONFIG_ADDR, 8'hbf);
    wr(MODE_CONFIG_ADDR, 8'h00);
    rd(MODE_CONFIG_ADDR, 8'h27);
    wr(KICK_ADDR, KICK_CODE);
    rd(KICK_ADDR, KICK_READ_RUN);
    wr(KICK_ADDR, KICK_CODE);
    `CHK(overflow_nmi_request_o, 1'b0)
    wr(KICK_ADDR, 8'h55);
    n = 0;
    while (overflow_nmi_request_o !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(overflow_nmi_request_o, 1'b1)
    n = 0;
    while (overflow_nmi_request_o === 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(n, NMI_WIDTH_CYCLES)
    `CHK(overflow_internal_reset_o, 1'b0)
    rd(KICK_ADDR, KICK_READ_RUN);
    $display("nmi test done");
    foreach (rm[k]) begin
      do_reset();
      wr(MODE_CONFIG_ADDR, rm[k]);
      wr(KICK_ADDR, KICK_CODE);
      wr(MODE_CONFIG_ADDR, rm[k]);
      rd(MODE_CONFIG_ADDR, rm[k]);
      repeat (3) @(negedge clock_i);
      `CHK(overflow_internal_reset_o, 1'b1)
      `CHK(overflow_nmi_request_o, 1'b0)
    end
    do_reset();
    wr(KICK_BIT_ADDR, 8'h01);
    repeat (3) @(negedge clock_i);
    `CHK(overflow_internal_reset_o, 1'b1)
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      do_reset();
      wr(MODE_CONFIG_ADDR, 8'hb8 | k[7:0]);
      rd(MODE_CONFIG_ADDR, 8'h20 | k[7:0]);
    end
    do_reset();
    wr(MODE_CONFIG_ADDR, 8'h00);
    wr(KICK_ADDR, KICK_CODE);
    wr(KICK_ADDR, 8'h55);
    repeat (3) @(negedge clock_i);
    `CHK(overflow_nmi_request_o, 1'b0)
    `CHK(overflow_internal_reset_o, 1'b0)
    $display("mode test done");
    end_sim();
  end
endmodule
`default_nettype wire
